//--- design/clhrp_port.sv
// Host register port of the character display controller
`timescale 1ns/1ps
module clhrp_port #(
    parameter int BUSY_CYCLES = clhrp_pkg::BUSY_CYC
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       four_bit_mode,
    input  wire logic       e_pin,
    input  wire logic       register_select_line,
    input  wire logic       rw_pin,
    input  wire logic [7:0] db_i,
    output logic      [7:0] db_o,
    output logic      [7:0] db_oe,
    output logic            busy_flag,
    input  wire logic [1:0] scan_line,
    input  wire logic [4:0] scan_col,
    output logic      [7:0] scan_code,
    output logic            scan_from_glyph_ram,
    output logic            scan_tall
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [6:0] text_index(input logic [6:0] a);
        if (a[6]) begin
            return a - clhrp_pkg::BANK_HI_BASE + clhrp_pkg::TEXT_HI_IDX;
        end
        // Gap between the banks maps past the end, so it never aliases the upper bank
        return (a > clhrp_pkg::BANK_LO_TOP) ? 7'h7f : a;
    endfunction

    function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                           input logic glyph);
        logic [6:0] r;
        r = up ? a + 7'h01 : a - 7'h01;
        if (glyph) begin
            r = {1'b0, r[5:0]};
        end else if (up && a == clhrp_pkg::BANK_LO_TOP) begin
            r = clhrp_pkg::BANK_HI_BASE;
        end else if (up && a == clhrp_pkg::BANK_HI_TOP) begin
            r = 7'h00;
        end else if (!up && a == 7'h00) begin
            r = clhrp_pkg::BANK_HI_TOP;
        end else if (!up && a == clhrp_pkg::BANK_HI_BASE) begin
            r = clhrp_pkg::BANK_LO_TOP;
        end
        return r;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic       e_s1_q, e_s2_q, e_d_q;
    logic       rs_s1_q, rs_s2_q;
    logic       rw_s1_q, rw_s2_q;
    logic [7:0] db_s1_q, db_s2_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            e_s1_q  <= 1'b0;
            e_s2_q  <= 1'b0;
            e_d_q   <= 1'b0;
            rs_s1_q <= 1'b0;
            rs_s2_q <= 1'b0;
            rw_s1_q <= 1'b0;
            rw_s2_q <= 1'b0;
            db_s1_q <= 8'h00;
            db_s2_q <= 8'h00;
        end else if (ce) begin
            e_s1_q  <= e_pin;
            e_s2_q  <= e_s1_q;
            e_d_q   <= e_s2_q;
            rs_s1_q <= register_select_line;
            rs_s2_q <= rs_s1_q;
            rw_s1_q <= rw_pin;
            rw_s2_q <= rw_s1_q;
            db_s1_q <= db_i;
            db_s2_q <= db_s1_q;
        end
    end

    logic e_rise, e_fall;
    assign e_rise = e_s2_q && !e_d_q;
    assign e_fall = !e_s2_q && e_d_q;

    // ****************************************
    // Nibble pairing
    // ****************************************
    logic       nib_q;
    logic [3:0] hi_q;
    logic       acc_done;
    logic [7:0] wr_byte;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nib_q <= 1'b0;
            hi_q  <= 4'h0;
        end else if (ce) begin
            if (!four_bit_mode) begin
                nib_q <= 1'b0;
            end else if (e_fall) begin
                nib_q <= !nib_q;
                if (!nib_q) begin
                    hi_q <= db_s2_q[7:4];
                end
            end
        end
    end

    assign acc_done = e_fall && (!four_bit_mode || nib_q);
    assign wr_byte  = four_bit_mode ? {hi_q, db_s2_q[7:4]} : db_s2_q;

    // ****************************************
    // Access decode
    // ****************************************
    logic busy_q_n;
    logic cmd_wr, dat_wr, dat_rd;
    assign busy_q_n = !busy_flag;
    // Accesses other than status reads are dropped while busy
    assign cmd_wr = acc_done && rs_s2_q == clhrp_pkg::SEL_CMD
                 && rw_s2_q == clhrp_pkg::DIR_WRITE && busy_q_n;
    assign dat_wr = acc_done && rs_s2_q == clhrp_pkg::SEL_DATA
                 && rw_s2_q == clhrp_pkg::DIR_WRITE && busy_q_n;
    assign dat_rd = acc_done && rs_s2_q == clhrp_pkg::SEL_DATA
                 && rw_s2_q == clhrp_pkg::DIR_READ && busy_q_n;

    logic set_text, set_glyph, do_shift, do_entry, do_home;
    assign set_text  = cmd_wr && wr_byte[clhrp_pkg::CMD_TEXT_BIT];
    assign set_glyph = cmd_wr && wr_byte[7:6] == 2'b01;
    assign do_shift  = cmd_wr && wr_byte[7:5] == 3'b000 && wr_byte[clhrp_pkg::CMD_SHIFT_BIT];
    assign do_entry  = cmd_wr && wr_byte[7:3] == 5'b00000 && wr_byte[clhrp_pkg::CMD_ENTRY_BIT];
    assign do_home   = cmd_wr && wr_byte[7:2] == 6'b000000 && wr_byte[clhrp_pkg::CMD_HOME_BIT];

    // ****************************************
    // Pointer, target and entry mode
    // ****************************************
    logic [6:0] ac_q;
    logic       sel_glyph_q;
    logic       entry_up_q, entry_s_q;
    logic [5:0] shift_q;
    logic [6:0] ac_stepped;

    assign ac_stepped = ac_step(ac_q, entry_up_q, sel_glyph_q);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ac_q        <= 7'h00;
            sel_glyph_q <= 1'b0;
            entry_up_q  <= clhrp_pkg::ENTRY_UP_RST;
            entry_s_q   <= clhrp_pkg::ENTRY_S_RST;
        end else if (ce) begin
            if (set_text) begin
                ac_q        <= wr_byte[6:0];
                sel_glyph_q <= 1'b0;
            end else if (set_glyph) begin
                ac_q        <= {1'b0, wr_byte[5:0]};
                sel_glyph_q <= 1'b1;
            end else if (do_home) begin
                ac_q        <= 7'h00;
                sel_glyph_q <= 1'b0;
            end else if (do_shift && !wr_byte[clhrp_pkg::SHIFT_SC_BIT]) begin
                ac_q <= ac_step(ac_q, wr_byte[clhrp_pkg::SHIFT_RL_BIT], sel_glyph_q);
            end else if (dat_wr || dat_rd) begin
                ac_q <= ac_stepped;
            end
            if (do_entry) begin
                entry_up_q <= wr_byte[clhrp_pkg::ENTRY_ID_BIT];
                entry_s_q  <= wr_byte[clhrp_pkg::ENTRY_S_BIT];
            end
        end
    end

    // ****************************************
    // Display shift
    // ****************************************
    logic shift_now, shift_left;
    assign shift_now  = (do_shift && wr_byte[clhrp_pkg::SHIFT_SC_BIT])
                     || (dat_wr && entry_s_q);
    assign shift_left = do_shift ? wr_byte[clhrp_pkg::SHIFT_RL_BIT] == 1'b0 : entry_up_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= 6'h00;
        end else if (ce) begin
            if (do_home) begin
                shift_q <= 6'h00;
            end else if (shift_now && shift_left) begin
                shift_q <= (shift_q == 6'(clhrp_pkg::BANK_LEN - 1)) ? 6'h00 : shift_q + 6'h01;
            end else if (shift_now) begin
                shift_q <= (shift_q == 6'h00) ? 6'(clhrp_pkg::BANK_LEN - 1) : shift_q - 6'h01;
            end
        end
    end

    // ****************************************
    // Busy timer
    // ****************************************
    logic [clhrp_pkg::BUSY_CNT_W-1:0] busy_cnt_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt_q <= '0;
        end else if (ce) begin
            if (cmd_wr || dat_wr || dat_rd) begin
                busy_cnt_q <= clhrp_pkg::BUSY_CNT_W'(BUSY_CYCLES);
            end else if (busy_cnt_q != '0) begin
                busy_cnt_q <= busy_cnt_q - 1'b1;
            end
        end
    end

    assign busy_flag = busy_cnt_q != '0;

    // ****************************************
    // RAMs and data register
    // ****************************************
    logic [7:0] text_rd, glyph_rd, scan_rd, host_rd;
    logic [6:0] scan_addr;
    logic [7:0] data_q;
    logic       fetch_q;

    clhrp_ram #(.DEPTH(clhrp_pkg::TEXT_DEPTH), .AW(7)) u_text_buffer_ram (
        .mclk    (mclk),
        .ce      (ce),
        .we      (dat_wr && !sel_glyph_q),
        .waddr   (text_index(ac_q)),
        .wdata   (wr_byte),
        .raddr_a (text_index(ac_q)),
        .rdata_a (text_rd),
        .raddr_b (text_index(scan_addr)),
        .rdata_b (scan_rd)
    );

    clhrp_ram #(.DEPTH(clhrp_pkg::GLYPH_DEPTH), .AW(6)) u_custom_glyph_ram (
        .mclk    (mclk),
        .ce      (ce),
        .we      (dat_wr && sel_glyph_q),
        .waddr   (ac_q[5:0]),
        .wdata   (wr_byte),
        .raddr_a (ac_q[5:0]),
        .rdata_a (glyph_rd),
        .raddr_b (6'h00),
        .rdata_b ()
    );

    assign host_rd = sel_glyph_q ? glyph_rd : text_rd;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_q <= 1'b0;
            data_q  <= 8'h00;
        end else if (ce) begin
            fetch_q <= set_text || set_glyph || dat_rd;
            if (dat_wr) begin
                data_q <= wr_byte;
            end else if (fetch_q) begin
                data_q <= host_rd;
            end
        end
    end

    // ****************************************
    // Read drive
    // ****************************************
    logic [7:0] out_q;
    logic [7:0] rd_byte;
    assign rd_byte = (rs_s2_q == clhrp_pkg::SEL_DATA) ? data_q : {busy_flag, ac_q};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= 8'h00;
        end else if (ce && e_rise) begin
            if (!four_bit_mode) begin
                out_q <= rd_byte;
            end else begin
                out_q <= nib_q ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0};
            end
        end
    end

    // Lower lines stay quiet in four-bit mode even if out_q holds an older byte
    assign db_o  = four_bit_mode ? {out_q[7:4], 4'h0} : out_q;
    assign db_oe = (e_s2_q && e_d_q && rw_s2_q == clhrp_pkg::DIR_READ)
                 ? (four_bit_mode ? 8'hf0 : 8'hff) : 8'h00;

    // ****************************************
    // Display scan
    // ****************************************
    clhrp_pos_map u_pos_map (
        .line_sel (scan_line),
        .col      (scan_col),
        .shift    (shift_q),
        .addr     (scan_addr)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scan_code           <= 8'h00;
            scan_from_glyph_ram <= 1'b0;
            scan_tall           <= 1'b0;
        end else if (ce) begin
            scan_code           <= scan_rd;
            scan_from_glyph_ram <= scan_rd[7:4] == 4'h0;
            scan_tall           <= scan_rd >= clhrp_pkg::TALL_FIRST;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_busy_after_cmd: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && cmd_wr) |=> busy_flag)
        else $error("busy flag not raised by command");
    a_busy_holds_ptr: assert property (@(posedge mclk) disable iff (!arst_n)
        busy_flag |=> $stable(ac_q))
        else $error("pointer moved while busy");
    a_addr_load_text: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && set_text) |=> (ac_q == $past(wr_byte[6:0]) && !sel_glyph_q))
        else $error("text address command not loaded");
    a_addr_fetch: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && (set_text || set_glyph)) ##1 ce[*2] |-> data_q == $past(host_rd))
        else $error("addressed byte not fetched");
    a_read_preload: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && dat_rd) ##1 ce[*2] |-> data_q == $past(host_rd))
        else $error("next byte not preloaded");
    a_ptr_step: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && (dat_wr || dat_rd)) |=> ac_q == $past(ac_stepped))
        else $error("pointer did not step");
    a_status_word: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && e_rise && !four_bit_mode && rs_s2_q == clhrp_pkg::SEL_CMD)
        |=> out_q == {$past(busy_flag), $past(ac_q)})
        else $error("status word wrong");
    a_drive_strobe: assert property (@(posedge mclk) disable iff (!arst_n)
        (db_oe != 8'h00) |-> (e_s2_q && rw_s2_q == clhrp_pkg::DIR_READ))
        else $error("data driven outside read strobe");
    a_nibble_lines: assert property (@(posedge mclk) disable iff (!arst_n)
        four_bit_mode |-> (db_oe[3:0] == 4'h0 && db_o[3:0] == 4'h0))
        else $error("lower lines used in four-bit mode");
endmodule

//--- design/clhrp_pkg.sv
// Constants of the character display host register port
// Functional notes
// - Select and direction lines choose command write, status read, data write, data read.
// - Exactly two host registers, command and data, each eight bits wide.
// - Command register is write-only; takes instructions and RAM address values.
// - A written data byte moves by internal operation into the selected RAM cell.
// - An address command fetches the addressed byte into the data register.
// - After each data read the data register preloads the byte at the next address.
// - While busy the busy flag is one and further commands are refused.
// - Status read shows busy on the top line and pointer on the lower seven.
// - Address command loads the pointer and selects text or glyph RAM together.
// - Every data write or read steps the pointer by one, direction from entry mode.
// - Text buffer holds 80 bytes; hidden cells stay usable as storage.
// - Unshifted lines start at 00H, 40H, 14H, 54H, twenty positions each.
// - Shifting moves windows circularly over 00H-27H and 40H-67H.
// - Glyph ROM maps codes to 208 short and 32 tall patterns.
// - Write data is captured at the falling edge of the strobe.
// - Read data is driven only while the strobe is high.
// - Four-bit mode uses upper lines only, high nibble first, low nibble second.
package clhrp_pkg;
    localparam int        DATA_W       = 8;
    localparam int        AC_W         = 7;
    localparam int        TEXT_DEPTH   = 80;
    localparam int        GLYPH_DEPTH  = 64;
    localparam int        LINE_LEN     = 20;
    localparam int        BANK_LEN     = 40;
    localparam logic [6:0] BANK_HI_BASE = 7'h40;
    localparam logic [6:0] BANK_LO_TOP  = 7'h27;
    localparam logic [6:0] BANK_HI_TOP  = 7'h67;
    localparam logic [6:0] TEXT_HI_IDX  = 7'h28;
    localparam logic [5:0] LINE34_OFF   = 6'h14;
    // Select and direction encodings
    localparam logic      SEL_CMD      = 1'b0;
    localparam logic      SEL_DATA     = 1'b1;
    localparam logic      DIR_WRITE    = 1'b0;
    localparam logic      DIR_READ     = 1'b1;
    // Command decode bit positions
    localparam int        CMD_TEXT_BIT  = 7;
    localparam int        CMD_GLYPH_BIT = 6;
    localparam int        CMD_SHIFT_BIT = 4;
    localparam int        CMD_ENTRY_BIT = 2;
    localparam int        CMD_HOME_BIT  = 1;
    localparam int        SHIFT_SC_BIT  = 3;
    localparam int        SHIFT_RL_BIT  = 2;
    localparam int        ENTRY_ID_BIT  = 1;
    localparam int        ENTRY_S_BIT   = 0;
    // Reset values
    localparam logic      ENTRY_UP_RST  = 1'b1;
    localparam logic      ENTRY_S_RST   = 1'b0;
    // Glyph code classes
    localparam logic [7:0] TALL_FIRST   = 8'he0;
    // Internal operation time
    localparam int        CLK_NS       = 10;
    localparam int        BUSY_NS      = 37000;
    localparam int        BUSY_CYC     = (BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int        BUSY_CNT_W   = 12;
endpackage

//--- design/clhrp_ram.sv
// Byte RAM with one write port and two read ports
`timescale 1ns/1ps
module clhrp_ram #(
    parameter int DEPTH = 80,
    parameter int AW    = 7
) (
    input  wire logic          mclk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [7:0]    rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [7:0]    rdata_b
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (ce && we && (int'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    // Out-of-range reads return zero
    assign rdata_a = (int'(raddr_a) < DEPTH) ? mem[raddr_a] : 8'h00;
    assign rdata_b = (int'(raddr_b) < DEPTH) ? mem[raddr_b] : 8'h00;
endmodule

//--- design/clhrp_pos_map.sv
// Display position to text buffer address mapping
`timescale 1ns/1ps
module clhrp_pos_map (
    input  wire logic [1:0] line_sel,
    input  wire logic [4:0] col,
    input  wire logic [5:0] shift,
    output logic      [6:0] addr
);
    logic [6:0] sum;
    logic [5:0] off;

    always_comb begin
        sum = 7'({1'b0, shift}) + 7'(col) + (line_sel[1] ? 7'(clhrp_pkg::LINE34_OFF) : 7'h00);
        if (sum >= 7'(clhrp_pkg::BANK_LEN)) begin
            sum = sum - 7'(clhrp_pkg::BANK_LEN);
        end
        off  = sum[5:0];
        addr = (line_sel[0] ? clhrp_pkg::BANK_HI_BASE : 7'h00) + 7'(off);
    end
endmodule

//--- tb/clhrp_host.sv
// Host processor model driving the strobe bus of the register port
`timescale 1ns/1ps
module clhrp_host (
    input  wire logic       mclk,
    input  wire logic       four_bit_mode,
    input  wire logic [7:0] db_o,
    input  wire logic [7:0] db_oe,
    output logic            e_pin,
    output logic            register_select_line,
    output logic            rw_pin,
    output logic      [7:0] db_i
);
    // ****
    // Strobe cycles
    // ****
    int hold_cyc = 6;

    initial begin
        e_pin = 1'b0;
        register_select_line = 1'b0;
        rw_pin = 1'b1;
        db_i = 8'h00;
    end

    // Lines not driven with data carry the inverse of their last value
    task automatic strobe(input logic rs, input logic rw, input logic [7:0] wb,
                          output logic [7:0] rb, output logic [7:0] oe);
        @(negedge mclk);
        register_select_line = rs;
        rw_pin = rw;
        db_i = rw ? ~db_i : wb;
        @(negedge mclk);
        e_pin = 1'b1;
        repeat (hold_cyc) @(negedge mclk);
        rb = db_o;
        oe = db_oe;
        e_pin = 1'b0;
        repeat (hold_cyc) @(negedge mclk);
        db_i = ~db_i;
    endtask

    task automatic access(input logic rs, input logic rw, input logic [7:0] wb,
                          output logic [7:0] rb, output logic [7:0] oe);
        logic [7:0] hi;
        logic [7:0] lo;
        if (four_bit_mode) begin
            strobe(rs, rw, {wb[7:4], ~db_i[3:0]}, hi, oe);
            strobe(rs, rw, {wb[3:0], ~db_i[3:0]}, lo, oe);
            rb = {hi[7:4], lo[7:4]};
        end else begin
            strobe(rs, rw, wb, rb, oe);
        end
    endtask

    task automatic wait_idle();
        logic [7:0] st;
        logic [7:0] oe;
        for (int i = 0; i < 100; i++) begin
            access(1'b0, 1'b1, 8'h00, st, oe);
            if (st[7] === 1'b0) return;
        end
    endtask
endmodule

//--- tb/clhrp_port_tb.sv
// Self-checking bench of the host register port
`timescale 1ns/1ps
module clhrp_port_tb;
    localparam int BUSY = 40;
    logic       mclk = 1'b0;
    logic       arst_n = 1'b0;
    logic       ce = 1'b1;
    logic       four_bit_mode = 1'b0;
    logic [1:0] scan_line = 2'h0;
    logic [4:0] scan_col = 5'h00;
    logic       e_pin, register_select_line, rw_pin, busy_flag;
    logic       scan_from_glyph_ram, scan_tall;
    logic [7:0] db_i, db_o, db_oe, scan_code, rb, oe;
    logic [7:0] tram [128];
    logic [7:0] gram [64];
    logic [6:0] ptr = 7'h00;
    logic       glyph = 1'b0;
    logic       up = 1'b1;
    logic       es = 1'b0;
    int         shift = 0;
    int         n_fail = 0;
    int         checks = 0;
    int         seed = 61476;

    always #5 mclk = ~mclk;

    clhrp_port #(.BUSY_CYCLES(BUSY)) clhrp_port_inst (
        .mclk(mclk), .arst_n(arst_n), .ce(ce), .four_bit_mode(four_bit_mode),
        .e_pin(e_pin), .register_select_line(register_select_line), .rw_pin(rw_pin),
        .db_i(db_i), .db_o(db_o), .db_oe(db_oe), .busy_flag(busy_flag),
        .scan_line(scan_line), .scan_col(scan_col), .scan_code(scan_code),
        .scan_from_glyph_ram(scan_from_glyph_ram), .scan_tall(scan_tall));

    clhrp_host clhrp_host_inst (
        .mclk(mclk), .four_bit_mode(four_bit_mode), .db_o(db_o), .db_oe(db_oe),
        .e_pin(e_pin), .register_select_line(register_select_line), .rw_pin(rw_pin),
        .db_i(db_i));

    // ****
    // Reference model and checks
    // ****
    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [6:0] nxt(input logic [6:0] a, input logic d);
        if (glyph) return d ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
        if (d) return (a == 7'h27) ? 7'h40 : (a == 7'h67) ? 7'h00 : a + 7'h01;
        return (a == 7'h40) ? 7'h27 : (a == 7'h00) ? 7'h67 : a - 7'h01;
    endfunction

    task automatic acc(input logic rs, input logic rw, input logic [7:0] wb);
        clhrp_host_inst.wait_idle();
        clhrp_host_inst.access(rs, rw, wb, rb, oe);
    endtask

    task automatic cmd(input logic [7:0] c);
        acc(1'b0, 1'b0, c);
        if (c[7]) begin
            ptr = c[6:0];
            glyph = 1'b0;
        end else if (c[6]) begin
            ptr = {1'b0, c[5:0]};
            glyph = 1'b1;
        end else if (c[4]) begin
            if (c[3]) shift += c[2] ? -1 : 1;
            else ptr = nxt(ptr, c[2]);
        end else if (c[2]) begin
            up = c[1];
            es = c[0];
        end else if (c[1]) begin
            ptr = 7'h00;
            shift = 0;
            glyph = 1'b0;
        end
    endtask

    task automatic wdat(input logic [7:0] b);
        acc(1'b1, 1'b0, b);
        if (glyph) gram[ptr[5:0]] = b;
        else tram[ptr] = b;
        ptr = nxt(ptr, up);
        if (es) shift += up ? 1 : -1;
    endtask

    task automatic rdat();
        acc(1'b1, 1'b1, 8'h00);
        compare("data", glyph ? gram[ptr[5:0]] : tram[ptr], rb);
        compare("drive", four_bit_mode ? 8'hf0 : 8'hff, oe);
        compare("release", 8'h00, db_oe);
        ptr = nxt(ptr, up);
    endtask

    task automatic stat();
        acc(1'b0, 1'b1, 8'h00);
        compare("status", {1'b0, ptr}, rb);
    endtask

    task automatic scan_all();
        int a;
        for (int l = 0; l < 4; l++) begin
            for (int c = 0; c < 20; c++) begin
                @(negedge mclk);
                scan_line = l[1:0];
                scan_col = c[4:0];
                @(negedge mclk);
                a = ((l > 1 ? 20 : 0) + c + shift % 40 + 40) % 40 + (l % 2 == 1 ? 64 : 0);
                compare("scan", tram[a], scan_code);
                compare("class", {6'h00, tram[a][7:4] == 4'h0, tram[a] >= 8'he0},
                        {6'h00, scan_from_glyph_ram, scan_tall});
            end
        end
    endtask

    // ****
    // Tests
    // ****
    initial begin
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        compare("busy", 8'h00, {7'h00, busy_flag});
        compare("oe", 8'h00, db_oe);
        stat();
        $display("test reset done");
        for (int i = 0; i < 80; i++) wdat(8'($random(seed)));
        cmd(8'h80);
        stat();
        cmd(8'ha5);
        repeat (5) rdat();
        scan_all();
        $display("test text buffer done");
        cmd(8'h18);
        scan_all();
        cmd(8'h1c);
        cmd(8'h1c);
        scan_all();
        $display("test shift done");
        cmd(8'h04);
        cmd(8'hc1);
        wdat(8'($random(seed)));
        wdat(8'($random(seed)));
        stat();
        cmd(8'h06);
        cmd(8'h14);
        cmd(8'h10);
        stat();
        cmd(8'h02);
        stat();
        scan_all();
        cmd(8'h07);
        wdat(8'($random(seed)));
        cmd(8'h06);
        scan_all();
        $display("test entry and home done");
        cmd(8'h48);
        for (int i = 0; i < 9; i++) wdat(8'($random(seed)));
        cmd(8'h48);
        repeat (8) rdat();
        stat();
        $display("test glyph done");
        cmd(8'h85);
        clhrp_host_inst.access(1'b0, 1'b1, 8'h00, rb, oe);
        compare("busy_status", 8'h85, rb);
        clhrp_host_inst.access(1'b0, 1'b0, 8'h90, rb, oe);
        stat();
        $display("test refusal done");
        clhrp_host_inst.wait_idle();
        clhrp_host_inst.hold_cyc = 4;
        four_bit_mode = 1'b1;
        cmd(8'hc3);
        wdat(8'h5a);
        cmd(8'hc3);
        rdat();
        stat();
        $display("test four bit done");
        complete_run();
    end

    initial begin
        #400000;
        n_fail++;
        complete_run();
    end
endmodule
